//--- logic/cep_engine_events.sv
// Event, status and power control of the block-cipher engine.
// Assumes a word-indexed register port and an OTP controller that pulses otp_done.
// Function
// - Block pass lasts 10 or 26 clocks for DES, 219/275/299 for AES key sizes.
// - DES session key encrypt or load takes 10 clocks, 20 for three parts.
// - AES 128-bit session key takes one block; longer ones take 438/550/598.
// - First AES decryption after a key change adds one key expansion pass.
// - Engine runs alone; the register port never stalls the processor.
// - Four interrupt sources: done, OTP complete, primary buffer free, counter wrap.
// - Done interrupt only when hardware ends the operation, never on software abort.
// - Status bit 5 shows the operation was aborted by software clearing go.
// - OTP interrupt on every OTP read or program completion when enabled.
// - Status bit 7 busy while any OTP operation runs, cleared at its end.
// - OTP read and program active bits follow their operation; all zero is idle.
// - After reset OTP read and busy stand until the initial key read ends.
// - Buffer free interrupt when primary buffer consumed, only in ECB and CBC.
// - Primary buffer busy stands until its data is taken in ECB and CBC, and until the pass ends in other modes.
// - Wrap interrupt only in counter mode and with nonzero counter width.
// - Status bit 4 set on every counter wrap event.
// - Sleep entry halts all operations and resets all state machines.
// - OTP programming in progress is halted on sleep entry.
// - Idle stops the engine only when stop-in-idle is set, as sleep.
// - Nonzero counter width increments the counter buffer after each operation.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module cep_engine_events
  import cep_pkg::*;
#(
  parameter int CTR_BITS = 128,
  parameter cep_cyc_t KEYEXP_CYCLES = CYC_KEYEXP_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire logic sleep_req,
  input wire logic idle_req,
  input wire logic otp_done,
  output logic otp_read_req,
  output logic otp_prog_req,
  output logic done_irq,
  output logic otp_irq,
  output logic free_irq,
  output logic wrap_irq
);

  localparam int CTR_WORDS = CTR_BITS / DW;

  if (CTR_BITS % DW != 0 || CTR_BITS < DW || CTR_BITS > 128 || KEYEXP_CYCLES == '0) begin : g_chk
    $error("cep_engine_events: unsupported counter width or key expansion count");
  end

  typedef struct packed {
    logic sidl;
    logic wrap_ie;
    logic done_ie;
    logic free_ie;
    logic go;
    logic [1:0] optype;
    logic decrypt;
    logic aes;
    logic [2:0] mode;
    logic [6:0] ctr_width;
    logic [1:0] keysz;
    logic [1:0] sksz;
    logic otp_ie;
    logic otp_read;
    logic otp_prog;
    logic abort;
    logic wrap;
    logic done_if;
    logic otp_if;
    logic free_if;
    logic wrap_if;
    logic pbusy;
    logic key_ready;
    logic halt_q;
    cep_state_t state;
    logic [CTR_BITS-1:0] counter;
    logic [DW-1:0] rdata;
    logic done_irq;
    logic otp_irq;
    logic free_irq;
    logic wrap_irq;
  } cep_eng_t;

  cep_eng_t q_reg;
  cep_eng_t q_next;

  cep_op_if op_if ();

  cep_op_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .op(op_if)
  );

  logic [CTR_BITS-1:0] ctr_mask;

  // The counter field covers width+1 low bits of the counter buffer.
  for (genvar i = 0; i < CTR_BITS; i++) begin : g_mask
    assign ctr_mask[i] = (7'(i) <= q_reg.ctr_width);
  end

  function automatic cep_cyc_t blk_cycles(input logic aes, input logic [1:0] keysz,
                                          input logic [1:0] optype, input logic [1:0] sksz);
    cep_cyc_t c;
    c = CYC_DES;
    if (!aes) begin
      if (optype != OP_DATA) begin
        c = (sksz == KEY_256) ? CYC_SK_DES3 : CYC_SK_DES12;
      end else begin
        c = (keysz == KEY_128) ? CYC_DES : CYC_3DES;
      end
    end else if (optype != OP_DATA && sksz != KEY_128) begin
      case (keysz)
        KEY_192: c = CYC_SK2_AES192;
        KEY_256: c = CYC_SK2_AES256;
        default: c = CYC_SK2_AES128;
      endcase
    end else begin
      case (keysz)
        KEY_192: c = CYC_AES192;
        KEY_256: c = CYC_AES256;
        default: c = CYC_AES128;
      endcase
    end
    return c;
  endfunction

  logic halt;
  logic otp_busy;
  logic start_c;
  logic stop_c;
  cep_cyc_t length_c;
  logic [CTR_BITS-1:0] ctr_inc;
  logic wrap_evt;
  logic sw_abort;
  logic run_done;
  logic [DW-1:0] st_word;
  logic [DW-1:0] rd_word;

  always_comb begin
    q_next = q_reg;
    start_c = 1'b0;
    stop_c = 1'b0;
    length_c = blk_cycles(q_reg.aes, q_reg.keysz, q_reg.optype, q_reg.sksz);
    halt = sleep_req | (idle_req & q_reg.sidl);
    otp_busy = q_reg.otp_read | q_reg.otp_prog;
    ctr_inc = q_reg.counter + {{(CTR_BITS-1){1'b0}}, 1'b1};
    wrap_evt = (q_reg.mode == MODE_CTR) && (q_reg.ctr_width != 7'h00) &&
               ((q_reg.counter & ctr_mask) == ctr_mask);
    run_done = (q_reg.state == ST_RUN) && op_if.finished;
    sw_abort = 1'b0;
    st_word = '0;
    st_word[ST_BUSY] = otp_busy;
    st_word[ST_PBUSY] = q_reg.pbusy;
    st_word[ST_ABORT] = q_reg.abort;
    st_word[ST_WRAP] = q_reg.wrap;
    st_word[ST_DONE_IF] = q_reg.done_if;
    st_word[ST_OTP_IF] = q_reg.otp_if;
    st_word[ST_FREE_IF] = q_reg.free_if;
    st_word[ST_WRAP_IF] = q_reg.wrap_if;

    // Software side: writes first, so that hardware events below win over clears.
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL_LOW: begin
          q_next.sidl = reg_wdata[CL_SIDL];
          q_next.wrap_ie = reg_wdata[CL_WRAP_IE];
          q_next.done_ie = reg_wdata[CL_DONE_IE];
          q_next.free_ie = reg_wdata[CL_FREE_IE];
          if (!q_reg.go) begin
            q_next.optype = reg_wdata[CL_OPTYPE_LSB +: 2];
            q_next.decrypt = reg_wdata[CL_DECRYPT];
            q_next.aes = reg_wdata[CL_AES];
            q_next.mode = reg_wdata[CL_MODE_LSB +: 3];
            if (reg_wdata[CL_GO] && !halt && !q_reg.halt_q && !otp_busy) begin
              q_next.go = 1'b1;
            end
          end else if (!reg_wdata[CL_GO] && !run_done) begin
            sw_abort = 1'b1;
          end
        end
        ADDR_CTRL_HIGH: begin
          if (!q_reg.go) begin
            q_next.ctr_width = reg_wdata[CH_CTRW_LSB +: 7];
            q_next.keysz = reg_wdata[CH_KEYSZ_LSB +: 2];
            q_next.sksz = reg_wdata[CH_SKSZ_LSB +: 2];
            q_next.key_ready = 1'b0;
          end
        end
        ADDR_STATUS: begin
          q_next.abort = q_reg.abort & ~reg_wdata[ST_ABORT];
          q_next.wrap = q_reg.wrap & ~reg_wdata[ST_WRAP];
          q_next.done_if = q_reg.done_if & ~reg_wdata[ST_DONE_IF];
          q_next.otp_if = q_reg.otp_if & ~reg_wdata[ST_OTP_IF];
          q_next.free_if = q_reg.free_if & ~reg_wdata[ST_FREE_IF];
          q_next.wrap_if = q_reg.wrap_if & ~reg_wdata[ST_WRAP_IF];
        end
        ADDR_OTP: begin
          q_next.otp_ie = reg_wdata[OT_IE];
          if (!otp_busy && !q_reg.go && !halt && !q_reg.halt_q) begin
            if (reg_wdata[OT_READ]) begin
              q_next.otp_read = 1'b1;
            end else if (reg_wdata[OT_PROG]) begin
              q_next.otp_prog = 1'b1;
            end
          end
        end
        default: begin
          for (int w = 0; w < CTR_WORDS; w++) begin
            if (!q_reg.go && reg_addr == ADDR_CTR_BASE + 4'(w)) begin
              q_next.counter[w*DW +: DW] = reg_wdata;
            end
          end
        end
      endcase
    end

    // OTP completion clears the activity bits and raises its event.
    if (otp_busy && otp_done) begin
      q_next.otp_read = 1'b0;
      q_next.otp_prog = 1'b0;
      q_next.otp_if = 1'b1;
    end

    case (q_reg.state)
      ST_IDLE: begin
        if (q_next.go && !q_reg.go) begin
          start_c = 1'b1;
          q_next.pbusy = 1'b1;
          length_c = blk_cycles(q_next.aes, q_next.keysz, q_next.optype, q_next.sksz);
          if (q_next.aes && q_next.decrypt && !q_reg.key_ready) begin
            length_c = KEYEXP_CYCLES;
            q_next.state = ST_KEYEXP;
          end else begin
            q_next.state = ST_RUN;
          end
        end
      end
      ST_KEYEXP: begin
        if (op_if.finished) begin
          q_next.key_ready = 1'b1;
          start_c = 1'b1;
          q_next.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (op_if.consumed && (q_reg.mode == MODE_ECB || q_reg.mode == MODE_CBC)) begin
          q_next.pbusy = 1'b0;
          q_next.free_if = 1'b1;
        end
        if (op_if.finished && !halt) begin
          q_next.go = 1'b0;
          q_next.pbusy = 1'b0;
          q_next.done_if = 1'b1;
          q_next.state = ST_IDLE;
          if (q_reg.ctr_width != 7'h00) begin
            q_next.counter = (q_reg.counter & ~ctr_mask) | (ctr_inc & ctr_mask);
          end
          if (wrap_evt) begin
            q_next.wrap = 1'b1;
            q_next.wrap_if = 1'b1;
          end
        end
      end
      default: begin
        q_next.state = ST_IDLE;
      end
    endcase

    // A software abort stops the pass without any done event.
    if (sw_abort) begin
      stop_c = 1'b1;
      q_next.go = 1'b0;
      q_next.pbusy = 1'b0;
      q_next.state = ST_IDLE;
      q_next.abort = 1'b1;
    end

    // Intermediate text is dropped with the state; the expanded key must be rebuilt.
    if (halt) begin
      stop_c = 1'b1;
      start_c = 1'b0;
      q_next.go = 1'b0;
      q_next.pbusy = 1'b0;
      q_next.state = ST_IDLE;
      q_next.key_ready = 1'b0;
      q_next.otp_prog = 1'b0;
      q_next.otp_read = 1'b0;
    end else if (q_reg.halt_q) begin
      q_next.otp_read = 1'b1;
    end
    q_next.halt_q = halt;

    rd_word = '0;
    case (reg_addr)
      ADDR_CTRL_LOW: begin
        rd_word[CL_SIDL] = q_reg.sidl;
        rd_word[CL_WRAP_IE] = q_reg.wrap_ie;
        rd_word[CL_DONE_IE] = q_reg.done_ie;
        rd_word[CL_FREE_IE] = q_reg.free_ie;
        rd_word[CL_GO] = q_reg.go;
        rd_word[CL_OPTYPE_LSB +: 2] = q_reg.optype;
        rd_word[CL_DECRYPT] = q_reg.decrypt;
        rd_word[CL_AES] = q_reg.aes;
        rd_word[CL_MODE_LSB +: 3] = q_reg.mode;
      end
      ADDR_CTRL_HIGH: begin
        rd_word[CH_CTRW_LSB +: 7] = q_reg.ctr_width;
        rd_word[CH_KEYSZ_LSB +: 2] = q_reg.keysz;
        rd_word[CH_SKSZ_LSB +: 2] = q_reg.sksz;
      end
      ADDR_STATUS: begin
        rd_word = st_word;
      end
      ADDR_OTP: begin
        rd_word[OT_IE] = q_reg.otp_ie;
        rd_word[OT_READ] = q_reg.otp_read;
        rd_word[OT_PROG] = q_reg.otp_prog;
      end
      default: begin
        for (int w = 0; w < CTR_WORDS; w++) begin
          if (reg_addr == ADDR_CTR_BASE + 4'(w)) begin
            rd_word = q_reg.counter[w*DW +: DW];
          end
        end
      end
    endcase
    q_next.rdata = reg_rd ? rd_word : '0;

    q_next.done_irq = q_next.done_if & q_next.done_ie;
    q_next.otp_irq = q_next.otp_if & q_next.otp_ie;
    q_next.free_irq = q_next.free_if & q_next.free_ie;
    q_next.wrap_irq = q_next.wrap_if & q_next.wrap_ie;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= '0;
      q_reg.sidl <= CTRL_LOW_RST[CL_SIDL];
      q_reg.ctr_width <= CTRL_HIGH_RST[CH_CTRW_LSB +: 7];
      q_reg.otp_read <= OTP_READ_RST;
      q_reg.state <= ST_IDLE;
    end else begin
      q_reg <= q_next;
    end
  end

  assign op_if.start = start_c;
  assign op_if.stop = stop_c;
  assign op_if.length = length_c;

  assign reg_rdata = q_reg.rdata;
  assign otp_read_req = q_reg.otp_read;
  assign otp_prog_req = q_reg.otp_prog;
  assign done_irq = q_reg.done_irq;
  assign otp_irq = q_reg.otp_irq;
  assign free_irq = q_reg.free_irq;
  assign wrap_irq = q_reg.wrap_irq;

endmodule

//--- logic/cep_pkg.sv
// Constants, register layout and timing counts of the engine event and power block.
// Assumes a 16-bit register port addressed by word index.
package cep_pkg;

  localparam int DW = 16;
  localparam int AW = 4;

  localparam logic [3:0] ADDR_CTRL_LOW = 4'h0;
  localparam logic [3:0] ADDR_CTRL_HIGH = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_OTP = 4'h3;
  localparam logic [3:0] ADDR_CTR_BASE = 4'h4;

  localparam int CL_SIDL = 13;
  localparam int CL_WRAP_IE = 12;
  localparam int CL_DONE_IE = 11;
  localparam int CL_FREE_IE = 10;
  localparam int CL_GO = 8;
  localparam int CL_OPTYPE_LSB = 6;
  localparam int CL_DECRYPT = 5;
  localparam int CL_AES = 4;
  localparam int CL_MODE_LSB = 0;

  localparam int CH_CTRW_LSB = 8;
  localparam int CH_KEYSZ_LSB = 5;
  localparam int CH_SKSZ_LSB = 0;

  localparam int ST_BUSY = 7;
  localparam int ST_PBUSY = 6;
  localparam int ST_ABORT = 5;
  localparam int ST_WRAP = 4;
  localparam int ST_DONE_IF = 3;
  localparam int ST_OTP_IF = 2;
  localparam int ST_FREE_IF = 1;
  localparam int ST_WRAP_IF = 0;

  localparam int OT_IE = 6;
  localparam int OT_READ = 5;
  localparam int OT_PROG = 0;

  localparam logic [15:0] CTRL_LOW_RST = 16'h0000;
  localparam logic [15:0] CTRL_HIGH_RST = 16'h0000;
  localparam logic OTP_READ_RST = 1'b1;

  localparam logic [2:0] MODE_ECB = 3'h0;
  localparam logic [2:0] MODE_CBC = 3'h1;
  localparam logic [2:0] MODE_CTR = 3'h4;
  localparam logic [1:0] OP_DATA = 2'h0;
  localparam logic [1:0] OP_SK_ENC = 2'h1;
  localparam logic [1:0] OP_SK_LOAD = 2'h2;
  localparam logic [1:0] KEY_128 = 2'h0;
  localparam logic [1:0] KEY_192 = 2'h1;
  localparam logic [1:0] KEY_256 = 2'h2;

  typedef logic [9:0] cep_cyc_t;

  localparam cep_cyc_t CYC_DES = 10'h00A;
  localparam cep_cyc_t CYC_3DES = 10'h01A;
  localparam cep_cyc_t CYC_AES128 = 10'h0DB;
  localparam cep_cyc_t CYC_AES192 = 10'h113;
  localparam cep_cyc_t CYC_AES256 = 10'h12B;
  localparam cep_cyc_t CYC_SK_DES12 = 10'h00A;
  localparam cep_cyc_t CYC_SK_DES3 = 10'h014;
  localparam cep_cyc_t CYC_SK2_AES128 = 10'h1B6;
  localparam cep_cyc_t CYC_SK2_AES192 = 10'h226;
  localparam cep_cyc_t CYC_SK2_AES256 = 10'h256;
  localparam cep_cyc_t CYC_CONSUME = 10'h001;
  localparam cep_cyc_t CYC_KEYEXP_DEF = 10'h0DB;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_KEYEXP = 3'b010,
    ST_RUN = 3'b100
  } cep_state_t;

endpackage

//--- logic/cep_op_if.sv
// Handshake between the engine control and its operation timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface cep_op_if;
  import cep_pkg::*;
  logic start;
  logic stop;
  cep_cyc_t length;
  logic consumed;
  logic finished;
  modport ctl (output start, output stop, output length, input consumed, input finished);
  modport tmr (input start, input stop, input length, output consumed, output finished);
endinterface

//--- logic/cep_op_timer.sv
// Operation timer: counts the latency of one block pass and reports when the
// primary input has been taken and when the pass ends.
// Assumes start and stop are one-cycle pulses from the control end.
`timescale 1ns/1ns
module cep_op_timer
  import cep_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  cep_op_if.tmr op
);

  typedef struct packed {
    logic active;
    cep_cyc_t count;
    cep_cyc_t len;
    logic consumed;
    logic finished;
  } cep_tmr_t;

  cep_tmr_t q_reg;
  cep_tmr_t q_next;

  always_comb begin
    q_next = q_reg;
    q_next.consumed = 1'b0;
    q_next.finished = 1'b0;
    if (op.stop) begin
      q_next.active = 1'b0;
      q_next.count = '0;
    end else if (op.start) begin
      q_next.active = 1'b1;
      q_next.count = CYC_CONSUME;
      q_next.len = op.length;
    end else if (q_reg.active) begin
      q_next.consumed = (q_reg.count == CYC_CONSUME);
      if (q_reg.count >= q_reg.len) begin
        q_next.finished = 1'b1;
        q_next.active = 1'b0;
      end else begin
        q_next.count = q_reg.count + CYC_CONSUME;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign op.consumed = q_reg.consumed;
  assign op.finished = q_reg.finished;

endmodule

//--- testbench/cep_engine_events_properties.sv
// Port checker for the engine event block.
// Assumes one clock, a synchronous active-low reset and the package register map.
`timescale 1ns/1ns
module cep_chk
  import cep_pkg::*;
#(
  parameter int CTR_BITS = 128,
  parameter cep_cyc_t KEYEXP_CYCLES = CYC_KEYEXP_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  input wire logic sleep_req,
  input wire logic idle_req,
  input wire logic otp_done,
  input wire logic otp_read_req,
  input wire logic otp_prog_req,
  input wire logic done_irq,
  input wire logic otp_irq,
  input wire logic free_irq,
  input wire logic wrap_irq
);
  // Stop-in-idle is shadowed from writes, since it cannot be seen at the ports.
  logic sidl_reg;
  logic sidl_next;
  logic wr_lo;
  logic wr_otp;
  assign wr_lo = reg_wr && reg_addr == ADDR_CTRL_LOW;
  assign wr_otp = reg_wr && reg_addr == ADDR_OTP;
  always_comb begin
    sidl_next = wr_lo ? reg_wdata[CL_SIDL] : sidl_reg;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sidl_reg <= 1'b0;
    end else begin
      sidl_reg <= sidl_next;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside answer cycle");
  busy_read_a: assert property (reg_rd && reg_addr == ADDR_STATUS |=>
    reg_rdata[ST_BUSY] == $past(otp_read_req || otp_prog_req))
    else $error("busy bit differs from OTP activity");
  otp_bits_a: assert property (reg_rd && reg_addr == ADDR_OTP |=>
    reg_rdata[OT_READ] == $past(otp_read_req) && reg_rdata[OT_PROG] == $past(otp_prog_req))
    else $error("OTP bits differ from requests");
  otp_excl_a: assert property (!(otp_read_req && otp_prog_req))
    else $error("OTP read and program together");
  prog_cause_a: assert property ($rose(otp_prog_req) |->
    $past(wr_otp) && $past(reg_wdata[OT_PROG]))
    else $error("program started unasked");
  read_end_a: assert property ($fell(otp_read_req) |->
    $past(otp_done) || $past(sleep_req) || $past(idle_req))
    else $error("OTP read ended without cause");
  sleep_halt_a: assert property (sleep_req |=> !otp_prog_req && !otp_read_req)
    else $error("OTP activity survived sleep");
  idle_halt_a: assert property (idle_req && sidl_reg |=> !otp_prog_req && !otp_read_req)
    else $error("OTP activity survived idle stop");
  idle_run_a: assert property (idle_req && !sidl_reg && !sleep_req && otp_read_req
    && !otp_done |=> otp_read_req)
    else $error("idle stopped OTP read");
  otp_irq_a: assert property ($rose(otp_irq) |->
    $past(otp_done) || $past(wr_otp) || $past(otp_done, 2) || $past(wr_otp, 2))
    else $error("OTP interrupt without cause");
  done_off_a: assert property (wr_lo && !reg_wdata[CL_DONE_IE] |-> ##[1:2] !done_irq)
    else $error("done interrupt while disabled");
  free_off_a: assert property (wr_lo && !reg_wdata[CL_FREE_IE] |-> ##[1:2] !free_irq)
    else $error("free interrupt while disabled");
  done_c: cover property ($rose(done_irq));
  wrap_c: cover property ($rose(wrap_irq));
  prog_halt_c: cover property (sleep_req && otp_prog_req);
endmodule
bind cep_engine_events cep_chk #(.CTR_BITS(CTR_BITS), .KEYEXP_CYCLES(KEYEXP_CYCLES)) cep_chk_inst (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req), .idle_req(idle_req),
  .otp_done(otp_done), .otp_read_req(otp_read_req), .otp_prog_req(otp_prog_req),
  .done_irq(done_irq), .otp_irq(otp_irq), .free_irq(free_irq), .wrap_irq(wrap_irq));

//--- testbench/testbench.sv
// Self-checking bench for the engine event block: latencies, flags, OTP and power modes.
// Assumes the package register map; key expansion is shortened to keep the run brief.
`timescale 1ns/1ns
module testbench;
  import cep_pkg::*;
  localparam cep_cyc_t KEXP = 10'h005;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] reg_addr = 4'h0;
  logic [DW-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_req = 1'b0;
  logic idle_req = 1'b0;
  logic otp_done = 1'b0;
  logic [DW-1:0] reg_rdata;
  logic otp_read_req;
  logic otp_prog_req;
  logic done_irq;
  logic otp_irq;
  logic free_irq;
  logic wrap_irq;
  int mismatches = 0;
  int num_checks = 0;
  logic [15:0] v;
  always #25 clk = ~clk;
  cep_engine_events #(.CTR_BITS(128), .KEYEXP_CYCLES(KEXP)) cep_engine_events_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req), .idle_req(idle_req),
    .otp_done(otp_done), .otp_read_req(otp_read_req), .otp_prog_req(otp_prog_req),
    .done_irq(done_irq), .otp_irq(otp_irq), .free_irq(free_irq), .wrap_irq(wrap_irq));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // A spare cycle after each strobe keeps one assignment per signal per time step.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done_irq !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      mismatches++;
      results();
    end
  endtask
  task automatic otp_finish(input logic irq);
    otp_done <= 1'b1;
    @(posedge clk);
    otp_done <= 1'b0;
    @(posedge clk);
    #1;
    check("otp idle", 16'({otp_read_req, otp_prog_req}), 16'h0000);
    check("otp irq", 16'(otp_irq), 16'(irq));
    @(posedge clk);
  endtask
  task automatic op(input logic [15:0] lo, input logic [15:0] hi, input bit wh, input int len,
                    output logic [15:0] st);
    int n;
    logic fr;
    fr = lo[2:0] == MODE_ECB || lo[2:0] == MODE_CBC;
    wr(ADDR_STATUS, 16'h003F);
    if (wh) begin
      wr(ADDR_CTRL_HIGH, hi);
    end
    wr(ADDR_CTRL_LOW, lo | 16'h1D00);
    wait_done(n);
    check("latency", 16'(n >= len - 1 && n <= len + 5), 16'h0001);
    check("free irq", 16'(free_irq), 16'(fr));
    @(posedge clk);
    rd(ADDR_STATUS, st);
    check("status", 16'({st[ST_PBUSY], st[ST_FREE_IF], st[ST_DONE_IF]}), 16'({fr, 1'b1}));
  endtask
  task automatic wrap_case(input logic [15:0] lo, input logic [6:0] w, input logic [15:0] pre,
                           input logic [15:0] post, input logic wp);
    logic [15:0] st;
    logic [15:0] c;
    wr(ADDR_CTRL_HIGH, {1'b0, w, 8'h00});
    wr(ADDR_CTR_BASE, pre);
    op(lo, 16'h0000, 1'b0, 10, st);
    rd(ADDR_CTR_BASE, c);
    #1;
    check("counter", c, post);
    check("wrap", 16'({st[ST_WRAP], st[ST_WRAP_IF], wrap_irq}), 16'({3{wp}}));
    @(posedge clk);
  endtask
  task automatic t_init();
    wr(ADDR_CTRL_LOW, 16'h0100);
    rd(ADDR_CTRL_LOW, v);
    check("go refused", 16'(v[CL_GO]), 16'h0000);
    rd(ADDR_STATUS, v);
    check("busy at start", 16'(v[ST_BUSY]), 16'h0001);
    rd(ADDR_OTP, v);
    check("reading at start", v, 16'h0020);
    otp_finish(1'b0);
    rd(ADDR_STATUS, v);
    check("status after read", v, 16'h0004);
    wr(ADDR_OTP, 16'h0040);
    #1;
    check("otp irq on enable", 16'(otp_irq), 16'h0001);
    @(posedge clk);
    wr(ADDR_STATUS, 16'h0004);
    #1;
    check("otp irq cleared", 16'(otp_irq), 16'h0000);
    @(posedge clk);
    $display("init test done");
  endtask
  task automatic t_ops();
    op(16'h0000, 16'h0000, 1'b1, 10, v);
    op(16'h0001, 16'h0040, 1'b1, 26, v);
    op(16'h0014, 16'h0000, 1'b1, 219, v);
    op(16'h0010, 16'h0020, 1'b1, 275, v);
    op(16'h0011, 16'h0040, 1'b1, 299, v);
    op(16'h0040, 16'h0001, 1'b1, 10, v);
    op(16'h0080, 16'h0002, 1'b1, 20, v);
    op(16'h0050, 16'h0001, 1'b1, 438, v);
    op(16'h0050, 16'h0021, 1'b1, 550, v);
    op(16'h0050, 16'h0042, 1'b1, 598, v);
    op(16'h0030, 16'h0000, 1'b1, 219 + int'(KEXP), v);
    op(16'h0030, 16'h0000, 1'b0, 219, v);
    $display("latency test done");
  endtask
  task automatic t_abort();
    wr(ADDR_STATUS, 16'h003F);
    wr(ADDR_CTRL_LOW, 16'h0911);
    repeat (20) @(posedge clk);
    wr(ADDR_CTRL_LOW, 16'h0811);
    rd(ADDR_CTRL_LOW, v);
    check("go after abort", 16'(v[CL_GO]), 16'h0000);
    rd(ADDR_STATUS, v);
    #1;
    check("abort and done", 16'({v[ST_ABORT], v[ST_DONE_IF], done_irq}), 16'h0004);
    @(posedge clk);
    $display("abort test done");
  endtask
  task automatic t_wrap();
    wrap_case(16'h0004, 7'h01, 16'h0003, 16'h0000, 1'b1);
    wrap_case(16'h0004, 7'h00, 16'hFFFF, 16'hFFFF, 1'b0);
    wrap_case(16'h0000, 7'h01, 16'h0003, 16'h0000, 1'b0);
    wrap_case(16'h0004, 7'h01, 16'h0001, 16'h0002, 1'b0);
    $display("wrap test done");
  endtask
  task automatic t_sleep();
    wr(ADDR_OTP, 16'h0041);
    rd(ADDR_OTP, v);
    check("programming", v, 16'h0041);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk);
    rd(ADDR_OTP, v);
    check("program halted", v, 16'h0060);
    wr(ADDR_STATUS, 16'h003F);
    otp_finish(1'b1);
    wr(ADDR_CTRL_LOW, 16'h0911);
    repeat (5) @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    rd(ADDR_CTRL_LOW, v);
    check("go after sleep", 16'(v[CL_GO]), 16'h0000);
    rd(ADDR_STATUS, v);
    check("no done on sleep", 16'(v[ST_DONE_IF]), 16'h0000);
    wr(ADDR_STATUS, 16'h0004);
    otp_finish(1'b1);
    $display("sleep test done");
  endtask
  task automatic t_idle();
    wr(ADDR_CTRL_LOW, 16'h2910);
    repeat (3) @(posedge clk);
    idle_req <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADDR_CTRL_LOW, v);
    check("go after idle stop", 16'(v[CL_GO]), 16'h0000);
    wr(ADDR_CTRL_LOW, 16'h0000);
    wr(ADDR_STATUS, 16'h003F);
    otp_finish(1'b1);
    op(16'h0000, 16'h0000, 1'b1, 10, v);
    idle_req <= 1'b0;
    @(posedge clk);
    $display("idle test done");
  endtask
  initial begin
    repeat (11) @(posedge clk);
    #1;
    check("read during reset", 16'(otp_read_req), 16'h0001);
    @(posedge clk);
    rst_n <= 1'b1;
    t_init();
    t_ops();
    t_abort();
    t_wrap();
    t_sleep();
    t_idle();
    results();
  end
endmodule
